/* core/board_bus_pkg.sv */
package board_bus_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_VECTOR = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CODES = 8'h0C;

   // ***************************************************************
   // ahb-lite encodings
   // ***************************************************************
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // ***************************************************************
   // rom-control codes and vector ports
   // ***************************************************************
   localparam int CODE_W = 5;
   localparam logic [4:0] CODE_FETCH = 5'h00;
   localparam logic [4:0] CODE_JUMP = 5'h01;
   localparam logic [4:0] CODE_RESET = 5'h08;
   localparam logic [7:0] PORT_VEC_UPPER = 8'h0C;
   localparam logic [7:0] PORT_VEC_LOWER = 8'h0D;

   // ***************************************************************
   // reset values and clock-source encodings
   // ***************************************************************
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] VECTOR_RESET = 16'h0000;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [1:0] CLK_SRC_ONBOARD = 2'h0;
   localparam logic [1:0] CLK_SRC_ALT = 2'h1;
   localparam logic [1:0] CLK_SRC_EXT = 2'h2;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef struct packed {
      logic cpu_irq_en;
      logic iface_irq_en;
      logic [1:0] clk_src;
      logic panel_fitted;
   } ctrl_reg_t;

   localparam ctrl_reg_t CTRL_RESET = 5'h00;

   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } vector_reg_t;

   typedef enum logic [1:0] {
      VEC_IDLE = 2'b00,
      VEC_UPPER = 2'b01,
      VEC_LOWER = 2'b10
   } vec_state_t;

endpackage

/* core/processor_board_bus_control.sv */
// Overview of operation
// RULE1 - five code lines; panel fitted selects panel group (decode only; rom_control_code output is always the registered cpu_rom_code)
// RULE2 - drive address bus unless dma owns it
// RULE3 - write bus driven whenever memory not idle
// RULE4 - read byte latched during memory slot
// RULE5 - dma may drive read bus afterward
// RULE6 - reset pulse on code 08 at cycle end
// RULE7 - fetch indicator on code 00, to panel
// RULE8 - jump indicator on code 01 to testpoint
// RULE9 - phase clock buffered, one of three sources
// RULE10 - cycle clock buffered, marks cycle end
// RULE11 - request needs enable, external irq, priority
// RULE12 - no panel: global request feeds processor
// RULE13 - enabled processor irq fetches vector 0C, 0D
// RULE14 - irq enabled status follows processor bit
// RULE15 - external reset clears pc and irq bit
// RULE16 - interrupt only while priority input inactive
// RULE17 - priority out inactive when nobody contemplating
// RULE18 - memory slot high while memory in use
// RULE19 - write strobe once address, data stable
// RULE20 - memory idle tells dma it may run
// RULE21 - store in progress asserted during stores
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
module processor_board_bus_control
   import board_bus_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // rom-control groups
   input wire logic [CODE_W-1:0] cpu_rom_code,
   input wire logic [CODE_W-1:0] panel_rom_control_code,
   output logic [CODE_W-1:0] rom_control_code,
   // address bus
   input wire logic [15:0] cpu_address,
   input wire logic cpu_addr_active,
   input wire logic dma_active,
   output logic [15:0] memory_address_bus,
   output logic memory_address_oe,
   // data buses
   input wire logic [7:0] cpu_write_data,
   input wire logic cpu_store,
   output logic [7:0] memory_write_bus,
   output logic memory_write_oe,
   input wire logic [7:0] memory_read_bus,
   output logic [7:0] cpu_read_data,
   // memory timing
   input wire logic cpu_mem_slot,
   output logic memory_slot,
   output logic memory_idle,
   output logic ram_write_strobe,
   output logic store_in_progress,
   // decoded indicators
   output logic system_reset_pulse,
   output logic opcode_fetch_indicator,
   output logic panel_fetch_out,
   output logic jump_indicator,
   // clocks
   input wire logic [2:0] phase_clock_src,
   input wire logic cpu_cycle_clock,
   output logic phase_clock,
   output logic cycle_clock,
   // interrupts
   input wire logic external_irq_in_n,
   input wire logic priority_chain_in_n,
   output logic priority_chain_out_n,
   output logic global_irq_out,
   output logic global_irq_oe,
   input wire logic panel_irq_in_n,
   output logic irq_enabled_status,
   output logic irq_fetch_active,
   output logic [7:0] vector_port,
   output logic [15:0] program_counter,
   input wire logic external_reset_in_n
);

   // ***************************************************************
   // bus slave
   // ***************************************************************
   logic [7:0] addr_ff;
   logic wr_ff;
   logic rd_ff;
   ctrl_reg_t ctrl_ff;
   ctrl_reg_t nxt_ctrl;
   vector_reg_t vector_ff;
   vector_reg_t nxt_vector;

   wire bus_take = hsel & hready & (htrans == HTRANS_NONSEQ);
   wire wr_ctrl = wr_ff & (addr_ff == OFS_CTRL);
   wire wr_vector = wr_ff & (addr_ff == OFS_VECTOR);
   wire sel_ctrl = addr_ff == OFS_CTRL;
   wire sel_vector = addr_ff == OFS_VECTOR;
   wire sel_status = addr_ff == OFS_STATUS;
   wire sel_codes = addr_ff == OFS_CODES;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ff <= 8'h00;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
      end else begin
         addr_ff <= bus_take ? haddr[7:0] : addr_ff;
         wr_ff <= bus_take & hwrite;
         rd_ff <= bus_take & ~hwrite;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;

   // ***************************************************************
   // control and vector registers
   // ***************************************************************
   wire external_reset_in = ~external_reset_in_n;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = hwdata[4:0];
      end
      if (external_reset_in) begin
         nxt_ctrl.cpu_irq_en = 1'b0; // RULE15
      end
   end

   assign nxt_vector = wr_vector ? hwdata[15:0] : vector_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= CTRL_RESET;
         vector_ff <= VECTOR_RESET;
      end else begin
         ctrl_ff <= nxt_ctrl;
         vector_ff <= nxt_vector;
      end
   end

   // ***************************************************************
   // rom-control decode
   // ***************************************************************
   logic [CODE_W-1:0] code_ff;
   logic fetch_ff;
   logic panel_fetch_ff;
   logic jump_ff;
   logic system_reset_pulse_ff;

   wire [CODE_W-1:0] eff_code = ctrl_ff.panel_fitted ?
                                panel_rom_control_code : cpu_rom_code; // RULE1
   wire dec_fetch = eff_code == CODE_FETCH;
   wire dec_jump = eff_code == CODE_JUMP;
   wire dec_reset = eff_code == CODE_RESET;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_ff <= CODE_FETCH;
         fetch_ff <= 1'b0;
         panel_fetch_ff <= 1'b0;
         jump_ff <= 1'b0;
         system_reset_pulse_ff <= 1'b0;
      end else begin
         code_ff <= cpu_rom_code; // RULE1
         fetch_ff <= dec_fetch; // RULE7
         panel_fetch_ff <= dec_fetch & ctrl_ff.panel_fitted; // RULE7
         jump_ff <= dec_jump; // RULE8
         system_reset_pulse_ff <= dec_reset & cpu_cycle_clock; // RULE6
      end
   end

   assign rom_control_code = code_ff;
   assign opcode_fetch_indicator = fetch_ff;
   assign panel_fetch_out = panel_fetch_ff;
   assign jump_indicator = jump_ff;
   assign system_reset_pulse = system_reset_pulse_ff;

   // ***************************************************************
   // clocks
   // ***************************************************************
   logic phase_ff;
   logic cycle_ff;
   logic phase_sel;

   always_comb begin
      phase_sel = phase_clock_src[0];
      unique case (ctrl_ff.clk_src)
         CLK_SRC_ONBOARD: phase_sel = phase_clock_src[0];
         CLK_SRC_ALT: phase_sel = phase_clock_src[1];
         CLK_SRC_EXT: phase_sel = phase_clock_src[2];
         default: phase_sel = phase_clock_src[0];
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_ff <= 1'b0;
         cycle_ff <= 1'b0;
      end else begin
         phase_ff <= phase_sel; // RULE9
         cycle_ff <= cpu_cycle_clock; // RULE10
      end
   end

   assign phase_clock = phase_ff;
   assign cycle_clock = cycle_ff;

   // trailing edge of the cycle clock starts the next cycle
   wire cycle_end = cycle_ff & ~cpu_cycle_clock; // RULE10

   // ***************************************************************
   // memory buses and strobes
   // ***************************************************************
   logic [15:0] addr_bus_ff;
   logic addr_oe_ff;
   logic [7:0] wdata_ff;
   logic wdata_oe_ff;
   logic [7:0] rlatch_ff;
   logic slot_ff;
   logic idle_ff;
   logic strobe_ff;
   logic store_ff;

   wire idle_now = ~cpu_mem_slot; // RULE20
   wire drive_addr = cpu_addr_active & ~dma_active; // RULE2
   // strobe waits a cycle into the slot so address and data settle
   wire strobe_now = cpu_store & cpu_mem_slot & slot_ff & store_ff; // RULE19

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_bus_ff <= 16'h0000;
         addr_oe_ff <= 1'b0;
         wdata_ff <= 8'h00;
         wdata_oe_ff <= 1'b0;
      end else begin
         addr_bus_ff <= cpu_address; // RULE2
         addr_oe_ff <= drive_addr; // RULE2
         wdata_ff <= cpu_write_data; // RULE3
         wdata_oe_ff <= ~idle_now; // RULE3
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rlatch_ff <= LATCH_RESET;
      end else if (cpu_mem_slot) begin
         // outside the slot the latch holds; dma may own the bus then
         rlatch_ff <= memory_read_bus; // RULE4 RULE5
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slot_ff <= 1'b0;
         idle_ff <= 1'b1;
         strobe_ff <= 1'b0;
         store_ff <= 1'b0;
      end else begin
         slot_ff <= cpu_mem_slot; // RULE18
         idle_ff <= idle_now; // RULE20
         strobe_ff <= strobe_now; // RULE19
         store_ff <= cpu_store & ~idle_now; // RULE21
      end
   end

   assign memory_address_bus = addr_bus_ff;
   assign memory_address_oe = addr_oe_ff;
   assign memory_write_bus = wdata_ff;
   assign memory_write_oe = wdata_oe_ff;
   assign cpu_read_data = rlatch_ff;
   assign memory_slot = slot_ff;
   assign memory_idle = idle_ff;
   assign ram_write_strobe = strobe_ff;
   assign store_in_progress = store_ff;

   // ***************************************************************
   // interrupt request and priority chain
   // ***************************************************************
   logic greq_ff;
   logic prio_out_n_ff;
   logic en_status_ff;

   wire ext_irq = ~external_irq_in_n;
   wire higher_busy = ~priority_chain_in_n; // RULE16
   wire contemplating = ctrl_ff.iface_irq_en & ext_irq;
   wire greq_now = contemplating & ~higher_busy; // RULE11 RULE16
   wire proc_irq = ctrl_ff.panel_fitted ? ~panel_irq_in_n : greq_ff; // RULE12

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         greq_ff <= 1'b0;
         prio_out_n_ff <= 1'b1;
         en_status_ff <= 1'b0;
      end else begin
         greq_ff <= greq_now; // RULE11
         prio_out_n_ff <= ~(contemplating | higher_busy); // RULE17
         en_status_ff <= nxt_ctrl.cpu_irq_en; // RULE14
      end
   end

   // open-drain global line: pulled low while requesting
   assign global_irq_out = 1'b0;
   assign global_irq_oe = greq_ff;
   assign priority_chain_out_n = prio_out_n_ff;
   assign irq_enabled_status = en_status_ff;

   // ***************************************************************
   // interrupt vector fetch
   // ***************************************************************
   vec_state_t vec_ff;
   vec_state_t nxt_vec;
   logic [15:0] pc_ff;
   logic [15:0] nxt_pc;
   logic [7:0] port_ff;
   logic [7:0] nxt_port;

   wire vec_start = ctrl_ff.cpu_irq_en & proc_irq & cycle_end; // RULE13

   always_comb begin
      nxt_vec = vec_ff;
      nxt_pc = pc_ff;
      nxt_port = port_ff;
      unique case (vec_ff)
         VEC_IDLE: begin
            if (vec_start) begin
               nxt_vec = VEC_UPPER;
               nxt_port = PORT_VEC_UPPER; // RULE13
            end
         end
         VEC_UPPER: begin
            if (cycle_end) begin
               nxt_pc[15:8] = vector_ff.upper; // RULE13
               nxt_port = PORT_VEC_LOWER;
               nxt_vec = VEC_LOWER;
            end
         end
         VEC_LOWER: begin
            if (cycle_end) begin
               nxt_pc[7:0] = vector_ff.lower; // RULE13
               nxt_port = 8'h00;
               nxt_vec = VEC_IDLE;
            end
         end
         default: nxt_vec = VEC_IDLE;
      endcase
      if (external_reset_in) begin
         nxt_vec = VEC_IDLE;
         nxt_pc = PC_RESET; // RULE15
         nxt_port = 8'h00;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vec_ff <= VEC_IDLE;
         pc_ff <= PC_RESET;
         port_ff <= 8'h00;
      end else begin
         vec_ff <= nxt_vec;
         pc_ff <= nxt_pc;
         port_ff <= nxt_port;
      end
   end

   assign irq_fetch_active = vec_ff != VEC_IDLE;
   assign vector_port = port_ff;
   assign program_counter = pc_ff;

   // ***************************************************************
   // read data
   // ***************************************************************
   wire [31:0] rd_ctrl = {27'h0000000, ctrl_ff};
   wire [31:0] rd_vector = {16'h0000, vector_ff};
   wire [31:0] rd_status = {3'h0, jump_ff, fetch_ff, irq_fetch_active,
                            greq_ff, en_status_ff, rlatch_ff, pc_ff};
   wire [31:0] rd_codes = {22'h000000, cpu_rom_code, eff_code};

   assign hrdata = !rd_ff ? 32'h00000000 :
                   sel_ctrl ? rd_ctrl :
                   sel_vector ? rd_vector :
                   sel_status ? rd_status :
                   sel_codes ? rd_codes : 32'h00000000;

endmodule

/* test/bus_control_monitor.sv */
module bus_control_monitor
   import board_bus_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // watched inputs
   input wire logic [CODE_W-1:0] cpu_rom_code,
   input wire logic [CODE_W-1:0] panel_rom_control_code,
   input wire logic [15:0] cpu_address,
   input wire logic cpu_addr_active,
   input wire logic dma_active,
   input wire logic cpu_mem_slot,
   input wire logic cpu_cycle_clock,
   input wire logic priority_chain_in_n,
   input wire logic external_reset_in_n,
   // watched outputs
   input wire logic [15:0] memory_address_bus,
   input wire logic memory_address_oe,
   input wire logic memory_write_oe,
   input wire logic memory_idle,
   input wire logic memory_slot,
   input wire logic [7:0] cpu_read_data,
   input wire logic ram_write_strobe,
   input wire logic store_in_progress,
   input wire logic system_reset_pulse,
   input wire logic opcode_fetch_indicator,
   input wire logic priority_chain_out_n,
   input wire logic global_irq_oe,
   input wire logic [15:0] program_counter,
   input wire logic irq_enabled_status
);
   // ***************************************************************
   // decoded codes, both groups agree
   // ***************************************************************
   wire logic fetch_code = cpu_rom_code == CODE_FETCH && panel_rom_control_code == CODE_FETCH;
   wire logic reset_code = cpu_rom_code == CODE_RESET && panel_rom_control_code == CODE_RESET;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ***************************************************************
   // properties
   // ***************************************************************
   addr_drive_a: assert property (
      cpu_addr_active && !dma_active |=>
         memory_address_oe && memory_address_bus == $past(cpu_address))
      else $error("address bus not driven");
   addr_release_a: assert property (dma_active |=> !memory_address_oe)
      else $error("address bus kept during dma");
   write_drive_a: assert property (cpu_mem_slot |=> memory_write_oe && !memory_idle)
      else $error("write bus not driven in slot");
   idle_flag_a: assert property (!cpu_mem_slot |=> memory_idle && !memory_write_oe)
      else $error("memory idle missing");
   latch_hold_a: assert property (!cpu_mem_slot |=> $stable(cpu_read_data))
      else $error("read latch changed outside slot");
   reset_pulse_a: assert property (reset_code && cpu_cycle_clock |=> system_reset_pulse)
      else $error("reset pulse missing");
   pulse_window_a: assert property (!cpu_cycle_clock |=> !system_reset_pulse)
      else $error("reset pulse outside cycle clock");
   fetch_decode_a: assert property (fetch_code |=> opcode_fetch_indicator)
      else $error("fetch indicator missing");
   strobe_guard_a: assert property (
      ram_write_strobe |-> store_in_progress && memory_slot && $past(store_in_progress))
      else $error("write strobe before store settled");
   chain_block_a: assert property (
      !priority_chain_in_n |=> !global_irq_oe && !priority_chain_out_n)
      else $error("request despite higher priority");
   clear_pc_a: assert property (
      !external_reset_in_n |=> program_counter == PC_RESET && !irq_enabled_status)
      else $error("external reset did not clear");
endmodule

bind processor_board_bus_control bus_control_monitor u_mon (
   .hclk, .hresetn, .cpu_rom_code, .panel_rom_control_code, .cpu_address, .cpu_addr_active,
   .dma_active, .cpu_mem_slot, .cpu_cycle_clock, .priority_chain_in_n, .external_reset_in_n,
   .memory_address_bus, .memory_address_oe, .memory_write_oe, .memory_idle, .memory_slot,
   .cpu_read_data, .ram_write_strobe, .store_in_progress, .system_reset_pulse,
   .opcode_fetch_indicator, .priority_chain_out_n, .global_irq_oe, .program_counter,
   .irq_enabled_status
);

/* test/far_side_boards.sv */
module far_side_boards
   import board_bus_pkg::*;
(
   // clock
   input wire logic hclk,
   // from the processor board
   input wire logic [15:0] memory_address_bus,
   input wire logic memory_address_oe,
   input wire logic [7:0] memory_write_bus,
   input wire logic memory_slot,
   input wire logic ram_write_strobe,
   input wire logic store_in_progress,
   // dma board takes the read bus
   input wire logic dma_drive,
   // returned data
   output logic [7:0] memory_read_bus
);
   logic [7:0] mem [256];
   wire logic sel = memory_address_oe && memory_slot && !store_in_progress;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'hA5;
      end
   end
   always @(posedge hclk) begin
      if (ram_write_strobe && memory_address_oe) begin
         mem[memory_address_bus[7:0]] <= memory_write_bus;
      end
   end
   // open collector with pull-ups: released bus reads ff
   assign memory_read_bus = dma_drive ? 8'h5A :
                            (sel ? mem[memory_address_bus[7:0]] : 8'hFF);
endmodule

/* test/test_processor_board_bus_control.sv */
module test_processor_board_bus_control
   import board_bus_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2, phase_clock_src = 3'h0;
   logic [4:0] cpu_rom_code = 5'h1F, panel_rom_control_code = 5'h1F, rom_control_code;
   logic [15:0] cpu_address = 16'h0, memory_address_bus, program_counter;
   logic [7:0] cpu_write_data = 8'h0, memory_write_bus, memory_read_bus, cpu_read_data;
   logic [7:0] vector_port;
   logic cpu_addr_active = 1'b0, dma_active = 1'b0, cpu_store = 1'b0, cpu_mem_slot = 1'b0;
   logic cpu_cycle_clock = 1'b0, external_irq_in_n = 1'b1, priority_chain_in_n = 1'b1;
   logic external_reset_in_n = 1'b1, dma_drive = 1'b0, hreadyout, hresp;
   logic memory_address_oe, memory_write_oe, memory_slot, memory_idle, ram_write_strobe;
   logic store_in_progress, system_reset_pulse, opcode_fetch_indicator, panel_fetch_out;
   logic jump_indicator, phase_clock, cycle_clock, priority_chain_out_n, global_irq_oe;
   logic irq_enabled_status, irq_fetch_active, global_irq_out, panel_irq_in_n = 1'b1;
   int error_cnt = 0, total_checks = 0;
   always #20 hclk = ~hclk;

   processor_board_bus_control DUT (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .cpu_rom_code, .panel_rom_control_code, .rom_control_code,
      .cpu_address, .cpu_addr_active, .dma_active, .memory_address_bus, .memory_address_oe,
      .cpu_write_data, .cpu_store, .memory_write_bus, .memory_write_oe, .memory_read_bus,
      .cpu_read_data, .cpu_mem_slot, .memory_slot, .memory_idle, .ram_write_strobe,
      .store_in_progress, .system_reset_pulse, .opcode_fetch_indicator, .panel_fetch_out,
      .jump_indicator, .phase_clock_src, .cpu_cycle_clock, .phase_clock, .cycle_clock,
      .external_irq_in_n, .priority_chain_in_n, .priority_chain_out_n, .global_irq_out,
      .global_irq_oe, .panel_irq_in_n, .irq_enabled_status, .irq_fetch_active,
      .vector_port, .program_counter, .external_reset_in_n
   );
   far_side_boards far_end (
      .hclk, .memory_address_bus, .memory_address_oe, .memory_write_bus, .memory_slot,
      .ram_write_strobe, .store_in_progress, .dma_drive, .memory_read_bus
   );

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge hclk);
   endtask
   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         conclude();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      q = hrdata;
      check(hresp, HRESP_OKAY);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   task automatic cyc_end();
      cpu_cycle_clock <= 1'b1;
      step(1);
      cpu_cycle_clock <= 1'b0;
      step(3);
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      step(10);
      hresetn <= 1'b1;
      step(1);
      rd(OFS_CTRL, 32'h0);
      rd(OFS_STATUS, 32'h0);
      rd(OFS_CODES, 32'h3FF);
      check({memory_idle, priority_chain_out_n}, 2'b11);
      bus(1'b1, OFS_VECTOR, 32'hA55A);
      rd(OFS_VECTOR, 32'hA55A);
      bus(1'b1, OFS_STATUS, 32'hFFFF);
      rd(OFS_STATUS, 32'h0);
      bus(1'b1, 8'h10, 32'h1234);
      rd(8'h10, 32'h0);
      for (int i = 0; i < 3; i++) begin
         cpu_rom_code <= (i == 0) ? CODE_FETCH : (i == 1) ? CODE_JUMP : CODE_RESET;
         panel_rom_control_code <= (i == 0) ? CODE_FETCH : (i == 1) ? CODE_JUMP : CODE_RESET;
         cpu_cycle_clock <= 1'b1;
         step(2);
         check({opcode_fetch_indicator, jump_indicator, system_reset_pulse}, 3'b100 >> i);
         check(cycle_clock, 1'b1);
         check(rom_control_code, cpu_rom_code);
      end
      cpu_cycle_clock <= 1'b0;
      bus(1'b1, OFS_CTRL, 32'h01);
      cpu_rom_code <= CODE_JUMP;
      panel_rom_control_code <= CODE_FETCH;
      step(2);
      check({opcode_fetch_indicator, panel_fetch_out, jump_indicator}, 3'b110);
      check(rom_control_code, CODE_JUMP);
      for (int s = 0; s < 3; s++) begin
         bus(1'b1, OFS_CTRL, 32'(s * 2));
         phase_clock_src <= 3'h1 << s;
         step(2);
         check(phase_clock, 1'b1);
         phase_clock_src <= ~(3'h1 << s);
         step(2);
         check(phase_clock, 1'b0);
      end
      cpu_address <= 16'h12EF;
      cpu_addr_active <= 1'b1;
      cpu_write_data <= 8'h3C;
      cpu_store <= 1'b1;
      cpu_mem_slot <= 1'b1;
      step(4);
      check({memory_address_oe, memory_address_bus}, 17'h112EF);
      check({memory_write_oe, memory_write_bus, memory_idle}, 10'h278);
      check({memory_slot, store_in_progress, ram_write_strobe}, 3'h7);
      cpu_store <= 1'b0;
      step(4);
      check(cpu_read_data, 8'h3C);
      cpu_mem_slot <= 1'b0;
      dma_active <= 1'b1;
      dma_drive <= 1'b1;
      step(3);
      check({cpu_read_data, memory_address_oe, memory_idle}, 10'h0F1);
      dma_active <= 1'b0;
      dma_drive <= 1'b0;
      bus(1'b1, OFS_CTRL, 32'h18);
      external_irq_in_n <= 1'b0;
      priority_chain_in_n <= 1'b0;
      step(3);
      check({global_irq_oe, priority_chain_out_n}, 2'b00);
      priority_chain_in_n <= 1'b1;
      step(3);
      check({global_irq_oe, priority_chain_out_n, irq_enabled_status}, 3'b101);
      check(global_irq_out, 1'b0);
      cyc_end();
      check({irq_fetch_active, vector_port}, {1'b1, PORT_VEC_UPPER});
      cyc_end();
      check({program_counter[15:8], vector_port}, {8'hA5, PORT_VEC_LOWER});
      external_irq_in_n <= 1'b1;
      cyc_end();
      check({irq_fetch_active, vector_port, program_counter}, 25'hA55A);
      check(priority_chain_out_n, 1'b1);
      bus(1'b1, OFS_CTRL, 32'h19);
      panel_irq_in_n <= 1'b0;
      cyc_end();
      check({irq_fetch_active, vector_port}, {1'b1, PORT_VEC_UPPER});
      panel_irq_in_n <= 1'b1;
      cyc_end();
      cyc_end();
      check({irq_fetch_active, program_counter}, 17'hA55A);
      external_reset_in_n <= 1'b0;
      step(1);
      external_reset_in_n <= 1'b1;
      step(1);
      check({program_counter, irq_enabled_status}, 17'h0);
      rd(OFS_CTRL, 32'h09);
      conclude();
   end
endmodule
